// ### hdl/orc_pkg.sv
// Shared constants, command codes and decode helpers for the octal
// register and reset command link.
// Assumes one byte moves per link clock period in single transfer rate.
package orc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // First command bytes; the second byte is always the complement.
  localparam logic [7:0] NO_OPERATION_CMD  = 8'h00;
  localparam logic [7:0] RESET_ARM_CMD     = 8'h66;
  localparam logic [7:0] RESET_CMD         = 8'h99;
  localparam logic [7:0] STATUS_READ_CMD   = 8'h05;
  localparam logic [7:0] CONFIG_READ_CMD   = 8'h15;
  localparam logic [7:0] STATUS_WRITE_CMD  = 8'h01;
  localparam logic [7:0] CONFIG2_READ_CMD  = 8'h71;
  localparam logic [7:0] CONFIG2_WRITE_CMD = 8'h72;

  //////////////////////////////////////////////////////////////////////////
  // Frame layout and fixed register addresses.
  localparam int          ADDR_BYTES   = 4;
  localparam int          DUMMY_CYCLES = 4;
  localparam logic [31:0] STATUS_ADDR  = 32'h0000_0000;
  localparam logic [31:0] CONFIG_ADDR  = 32'h0000_0001;
  localparam logic [7:0]  BUS_IDLE     = 8'hff;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  CONFIG_RESET = 8'h00;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ARM,
    OP_RST,
    OP_SR_RD,
    OP_CR_RD,
    OP_SR_WR,
    OP_CR_WR,
    OP_CR2_RD,
    OP_CR2_WR,
    OP_BAD
  } orc_op_t;

  //////////////////////////////////////////////////////////////////////////
  // Maps an operation to the first byte of its code.
  function automatic logic [7:0] orc_first_byte(input orc_op_t op);
    case (op)
      OP_ARM:    return RESET_ARM_CMD;
      OP_RST:    return RESET_CMD;
      OP_SR_RD:  return STATUS_READ_CMD;
      OP_CR_RD:  return CONFIG_READ_CMD;
      OP_SR_WR:  return STATUS_WRITE_CMD;
      OP_CR_WR:  return STATUS_WRITE_CMD;
      OP_CR2_RD: return CONFIG2_READ_CMD;
      OP_CR2_WR: return CONFIG2_WRITE_CMD;
      default:   return NO_OPERATION_CMD;
    endcase
  endfunction

  // Maps a first byte back to an operation; shared write code reads as
  // the status write until the address settles it.
  function automatic orc_op_t orc_decode(input logic [7:0] b);
    case (b)
      NO_OPERATION_CMD:  return OP_NOP;
      RESET_ARM_CMD:     return OP_ARM;
      RESET_CMD:         return OP_RST;
      STATUS_READ_CMD:   return OP_SR_RD;
      CONFIG_READ_CMD:   return OP_CR_RD;
      STATUS_WRITE_CMD:  return OP_SR_WR;
      CONFIG2_READ_CMD:  return OP_CR2_RD;
      CONFIG2_WRITE_CMD: return OP_CR2_WR;
      default:           return OP_BAD;
    endcase
  endfunction

  function automatic logic orc_is_read(input orc_op_t op);
    return (op == OP_SR_RD) || (op == OP_CR_RD) || (op == OP_CR2_RD);
  endfunction

  function automatic logic orc_is_write(input orc_op_t op);
    return (op == OP_SR_WR) || (op == OP_CR_WR) || (op == OP_CR2_WR);
  endfunction

  function automatic logic orc_has_addr(input orc_op_t op);
    return orc_is_read(op) || orc_is_write(op);
  endfunction

endpackage

// ### hdl/orc_link_if.sv
// Octal link between the controller end and the flash end.
// Assumes an idle bus floats high when neither end drives it.
`timescale 1ns/1ps
interface orc_link_if;
  logic       sclk;
  logic       csN;
  logic [7:0] hostDq;
  logic       hostDqOe;
  logic [7:0] devDq;
  logic       devDqOe;
  logic [7:0] dq;

  // Resolved level of the shared data lines.
  assign dq = hostDqOe ? hostDq : (devDqOe ? devDq : orc_pkg::BUS_IDLE);

  modport host (
    output sclk,
    output csN,
    output hostDq,
    output hostDqOe,
    input  dq
  );

  modport device (
    input  sclk,
    input  csN,
    input  dq,
    output devDq,
    output devDqOe
  );
endinterface

// ### hdl/orc_device.sv
// Flash end: decodes reset and register commands arriving on the link.
// Assumes the link pins are asynchronous to clk and that the link clock
// is slow enough for clk to see every edge after synchronisation.
//
// Operation
// - No-op, arm, reset: two bytes only.
// - Status write 01/FE, zero address, one byte.
// - Last address byte picks config over status.
// - Config2 read 71/8E, address, dummy, byte.
// - Config2 write 72/8D, address, one byte.
// - Status/config reads: fixed address, dummy, byte.
// - Reset acts only right after arm.
// - Register reads use exactly four dummy cycles.
// - Register writes need the write enable latch.
`timescale 1ns/1ps
module orc_device
  import orc_pkg::*;
#(
  parameter int CFG2_DEPTH = 8
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  orc_link_if.device      link,
  input  wire logic       writeEnableLatch,
  output logic [7:0]      statusValue,
  output logic [7:0]      configValue,
  output logic            resetPulse,
  output logic            regWritePulse
);

  localparam int IDXW = (CFG2_DEPTH > 1) ? $clog2(CFG2_DEPTH) : 1;

  typedef enum logic [3:0] {
    PH_IDLE,
    PH_CMD1,
    PH_CMD2,
    PH_ADDR,
    PH_DUMMY,
    PH_RDATA,
    PH_WDATA,
    PH_NODATA,
    PH_IGNORE
  } orc_phase_t;

  typedef struct packed {
    logic                       csM;
    logic                       csS;
    logic                       sclkM;
    logic                       sclkS;
    logic                       sclkP;
    logic [7:0]                 dqM;
    logic [7:0]                 dqS;
    orc_phase_t                 ph;
    orc_op_t                    op;
    logic [7:0]                 cmd1;
    logic [3:0]                 cnt;
    logic [31:0]                addr;
    logic                       armed;
    logic [7:0]                 status;
    logic [7:0]                 cfgByte;
    logic [CFG2_DEPTH-1:0][7:0] cfg2;
    logic [7:0]                 dqOut;
    logic                       dqOe;
    logic                       resetPulse;
    logic                       writePulse;
  } orc_dev_reg_t;

  localparam orc_dev_reg_t DEV_RESET = '{
    csM:     1'b1,
    csS:     1'b1,
    ph:      PH_IDLE,
    op:      OP_NOP,
    status:  STATUS_RESET,
    cfgByte: CONFIG_RESET,
    dqOut:   BUS_IDLE,
    default: '0
  };

  orc_dev_reg_t r_q;
  orc_dev_reg_t r_d;

  //////////////////////////////////////////////////////////////////////////
  // Checks the gathered address against the operation; the shared write
  // code passes with either fixed address.
  function automatic logic addr_ok(input orc_op_t op,
                                   input logic [31:0] a);
    case (op)
      OP_SR_RD: return a == STATUS_ADDR;
      OP_CR_RD: return a == CONFIG_ADDR;
      OP_SR_WR: return (a == STATUS_ADDR) || (a == CONFIG_ADDR);
      default:  return 1'b1;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic          rise;
    logic          fall;
    logic [31:0]   nextAddr;
    orc_op_t       nextOp;
    logic [IDXW-1:0] idx;
    rise     = 1'b0;
    fall     = 1'b0;
    nextAddr = '0;
    nextOp   = OP_NOP;
    idx      = '0;

    r_d            = r_q;
    r_d.csM        = link.csN;
    r_d.csS        = r_q.csM;
    r_d.sclkM      = link.sclk;
    r_d.sclkS      = r_q.sclkM;
    r_d.sclkP      = r_q.sclkS;
    r_d.dqM        = link.dq;
    r_d.dqS        = r_q.dqM;
    r_d.resetPulse = 1'b0;
    r_d.writePulse = 1'b0;

    rise     = ~r_q.csS & r_q.sclkS & ~r_q.sclkP;
    fall     = ~r_q.csS & ~r_q.sclkS & r_q.sclkP;
    nextAddr = {r_q.addr[23:0], r_q.dqS};
    idx      = r_q.addr[IDXW-1:0];

    if (r_q.csS)
    begin
      // Frame end: commands without phases act here.
      if (r_q.ph == PH_NODATA)
      begin
        case (r_q.op)
          OP_ARM:
            r_d.armed = 1'b1;
          OP_RST:
          begin
            r_d.resetPulse = r_q.armed;
            r_d.armed      = 1'b0;
          end
          default:
            r_d.armed = 1'b0;
        endcase
      end
      else if ((r_q.ph != PH_IDLE) && (r_q.ph != PH_CMD1) &&
               (r_q.ph != PH_CMD2))
      begin
        r_d.armed = 1'b0;
      end
      r_d.ph   = PH_IDLE;
      r_d.dqOe = 1'b0;
    end
    else
    begin
      case (r_q.ph)
        PH_IDLE:
        begin
          r_d.ph  = PH_CMD1;
          r_d.cnt = '0;
        end
        PH_CMD1:
          if (rise)
          begin
            r_d.cmd1 = r_q.dqS;
            r_d.ph   = PH_CMD2;
          end
        PH_CMD2:
          if (rise)
          begin
            nextOp   = orc_decode(r_q.cmd1);
            r_d.op   = nextOp;
            r_d.addr = '0;
            r_d.cnt  = '0;
            if ((r_q.dqS != ~r_q.cmd1) || (nextOp == OP_BAD))
              r_d.ph = PH_IGNORE;
            else if (orc_has_addr(nextOp))
              r_d.ph = PH_ADDR;
            else
              r_d.ph = PH_NODATA;
          end
        PH_ADDR:
          if (rise)
          begin
            r_d.addr = nextAddr;
            r_d.cnt  = r_q.cnt + 4'h1;
            if (r_q.cnt == 4'(ADDR_BYTES - 1))
            begin
              r_d.cnt = '0;
              if (!addr_ok(r_q.op, nextAddr))
                r_d.ph = PH_IGNORE;
              else if (orc_is_read(r_q.op))
                r_d.ph = PH_DUMMY;
              else
                r_d.ph = PH_WDATA;
              if ((r_q.op == OP_SR_WR) && (nextAddr == CONFIG_ADDR))
                r_d.op = OP_CR_WR;
            end
          end
        PH_DUMMY:
          if (rise)
          begin
            r_d.cnt = r_q.cnt + 4'h1;
            if (r_q.cnt == 4'(DUMMY_CYCLES - 1))
              r_d.ph = PH_RDATA;
          end
        PH_RDATA:
          if (fall)
          begin
            r_d.dqOe = 1'b1;
            case (r_q.op)
              OP_SR_RD: r_d.dqOut = r_q.status;
              OP_CR_RD: r_d.dqOut = r_q.cfgByte;
              default:  r_d.dqOut = r_q.cfg2[idx];
            endcase
          end
        PH_WDATA:
          if (rise)
          begin
            r_d.ph = PH_IGNORE;
            if (writeEnableLatch)
            begin
              r_d.writePulse = 1'b1;
              case (r_q.op)
                OP_SR_WR: r_d.status    = r_q.dqS;
                OP_CR_WR: r_d.cfgByte   = r_q.dqS;
                default:  r_d.cfg2[idx] = r_q.dqS;
              endcase
            end
          end
        PH_NODATA:
          if (rise)
            r_d.ph = PH_IGNORE;
        PH_IGNORE:
          r_d.ph = PH_IGNORE;
        default:
          r_d.ph = PH_IGNORE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r_q <= DEV_RESET;
    else
      r_q <= r_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs and link drive come straight from the state register.
  assign statusValue   = r_q.status;
  assign configValue   = r_q.cfgByte;
  assign resetPulse    = r_q.resetPulse;
  assign regWritePulse = r_q.writePulse;
  assign link.devDq    = r_q.dqOut;
  assign link.devDqOe  = r_q.dqOe;

endmodule

// ### hdl/orc_host.sv
// Controller end: sends one reset or register command per request.
// Assumes the flash end answers reads within half a link clock period.
`timescale 1ns/1ps
module orc_host
  import orc_pkg::*;
#(
  parameter int SCLK_HALF = 10
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  orc_link_if.host         link,
  input  wire logic        start,
  input  orc_op_t          op,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdata
);

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_RUN,
    HS_GAP
  } orc_host_state_t;

  typedef struct packed {
    orc_host_state_t st;
    logic [7:0]      div;
    logic            sclk;
    logic            csN;
    logic [7:0]      dqOut;
    logic            dqOe;
    logic [3:0]      step;
    logic [3:0]      last;
    orc_op_t         op;
    logic [31:0]     addr;
    logic [7:0]      wdata;
    logic [7:0]      rdata;
    logic            busy;
    logic            done;
    logic [7:0]      dqM;
    logic [7:0]      dqS;
  } orc_host_reg_t;

  localparam orc_host_reg_t HOST_RESET = '{
    st:      HS_IDLE,
    csN:     1'b1,
    op:      OP_NOP,
    dqOut:   BUS_IDLE,
    default: '0
  };
  localparam logic [7:0] DIV_LAST = 8'(SCLK_HALF - 1);
  localparam logic [3:0] CMD_STEPS = 4'h2;
  localparam logic [3:0] ADDR_STEPS = 4'(ADDR_BYTES);
  localparam logic [3:0] DUMMY_STEPS = 4'(DUMMY_CYCLES);

  orc_host_reg_t r_q;
  orc_host_reg_t r_d;

  //////////////////////////////////////////////////////////////////////////
  // Byte sent in a given step and whether the host drives it.
  function automatic logic [8:0] step_byte(input orc_op_t o,
                                           input logic [31:0] a,
                                           input logic [7:0] w,
                                           input logic [3:0] s);
    logic [7:0] b1;
    b1 = orc_first_byte(o);
    if (s == 4'h0)
      return {1'b1, b1};
    if (s == 4'h1)
      return {1'b1, ~b1};
    if (s < CMD_STEPS + ADDR_STEPS)
      return {1'b1, a[8'(31 - 8 * (s - CMD_STEPS)) -: 8]};
    if (orc_is_write(o))
      return {1'b1, w};
    return {1'b0, BUS_IDLE};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [8:0]  nb;
    logic [31:0] fixedAddr;
    nb        = '0;
    fixedAddr = '0;

    r_d      = r_q;
    r_d.dqM  = link.dq;
    r_d.dqS  = r_q.dqM;
    r_d.done = 1'b0;

    case (r_q.st)
      HS_IDLE:
        if (start)
        begin
          case (op)
            OP_SR_RD: fixedAddr = STATUS_ADDR;
            OP_SR_WR: fixedAddr = STATUS_ADDR;
            OP_CR_RD: fixedAddr = CONFIG_ADDR;
            OP_CR_WR: fixedAddr = CONFIG_ADDR;
            default:  fixedAddr = addr;
          endcase
          nb         = step_byte(op, fixedAddr, wdata, 4'h0);
          r_d.op     = op;
          r_d.addr   = fixedAddr;
          r_d.wdata  = wdata;
          r_d.step   = '0;
          r_d.div    = '0;
          r_d.sclk   = 1'b0;
          r_d.csN    = 1'b0;
          r_d.dqOut  = nb[7:0];
          r_d.dqOe   = nb[8];
          r_d.busy   = 1'b1;
          r_d.st     = HS_RUN;
          if (orc_is_read(op))
            r_d.last = CMD_STEPS + ADDR_STEPS + DUMMY_STEPS;
          else if (orc_is_write(op))
            r_d.last = CMD_STEPS + ADDR_STEPS;
          else
            r_d.last = CMD_STEPS - 4'h1;
        end
      HS_RUN:
      begin
        r_d.div = r_q.div + 8'h01;
        if (r_q.div == DIV_LAST)
        begin
          r_d.div  = '0;
          r_d.sclk = ~r_q.sclk;
          if (!r_q.sclk)
          begin
            if (orc_is_read(r_q.op) && (r_q.step == r_q.last))
              r_d.rdata = r_q.dqS;
          end
          else if (r_q.step == r_q.last)
          begin
            r_d.csN   = 1'b1;
            r_d.dqOe  = 1'b0;
            r_d.dqOut = BUS_IDLE;
            r_d.st    = HS_GAP;
          end
          else
          begin
            nb        = step_byte(r_q.op, r_q.addr, r_q.wdata,
                                  r_q.step + 4'h1);
            r_d.step  = r_q.step + 4'h1;
            r_d.dqOut = nb[7:0];
            r_d.dqOe  = nb[8];
          end
        end
      end
      HS_GAP:
      begin
        // Deselect time lets the flash end see the frame end.
        r_d.div = r_q.div + 8'h01;
        if (r_q.div == DIV_LAST)
        begin
          r_d.div  = '0;
          r_d.busy = 1'b0;
          r_d.done = 1'b1;
          r_d.st   = HS_IDLE;
        end
      end
      default:
        r_d.st = HS_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r_q <= HOST_RESET;
    else
      r_q <= r_d;
  end

  assign busy          = r_q.busy;
  assign done          = r_q.done;
  assign rdata         = r_q.rdata;
  assign link.sclk     = r_q.sclk;
  assign link.csN      = r_q.csN;
  assign link.hostDq   = r_q.dqOut;
  assign link.hostDqOe = r_q.dqOe;

endmodule

// ### tb/orc_link_asserts.sv
// Concurrent checks on the octal link between the controller and flash ends.
// Assumes the controller end runs with a link clock half period of ten clocks.
`timescale 1ns/1ps
module orc_link_asserts
  import orc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sclk,
  input wire logic       csN,
  input wire logic [7:0] hostDq,
  input wire logic       hostDqOe,
  input wire logic [7:0] devDq,
  input wire logic       devDqOe,
  input wire logic [7:0] dq
);
  logic       sclkPrev_q;
  logic       csNPrev_q;
  logic [3:0] riseCnt_q;
  logic [7:0] firstByte_q;

  ////////////////////////////////////////////////////////////////////////////
  // Counts link clock rises within the current frame.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclkPrev_q  <= 1'b0;
      csNPrev_q   <= 1'b1;
      riseCnt_q   <= 4'h0;
      firstByte_q <= 8'h00;
    end
    else
    begin
      sclkPrev_q <= sclk;
      csNPrev_q  <= csN;
      if (!csN && csNPrev_q)
        riseCnt_q <= 4'h0;
      else if (sclk && !sclkPrev_q && !csN)
        riseCnt_q <= riseCnt_q + 4'h1;
      if (sclk && !sclkPrev_q && riseCnt_q == 4'h0)
        firstByte_q <= dq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_no_clash; !(hostDqOe && devDqOe); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data lines");
  property p_quiet_idle; csN |-> !hostDqOe && !sclk; endproperty
  a_quiet_idle: assert property (p_quiet_idle)
    else $error("link active while deselected");
  property p_hold_data; sclk |-> $stable(hostDq); endproperty
  a_hold_data: assert property (p_hold_data)
    else $error("host data moved while link clock high");
  property p_sclk_high; $rose(sclk) |=> sclk [*8]; endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("link clock high phase too short");
  property p_complement;
    $rose(sclk) && !csN && riseCnt_q == 4'h1 && hostDqOe |-> dq == ~firstByte_q;
  endproperty
  a_complement: assert property (p_complement)
    else $error("second code byte is not the complement");
  property p_dummy; $rose(devDqOe) |-> riseCnt_q == 4'ha && !csN; endproperty
  a_dummy: assert property (p_dummy)
    else $error("read data not after four dummy cycles");
  property p_frame_len;
    $rose(csN) |-> riseCnt_q inside {4'h2, 4'h7, 4'hb};
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length is not a legal count");
  property p_release; $rose(csN) |-> ##[1:8] !devDqOe; endproperty
  a_release: assert property (p_release)
    else $error("flash end kept driving after deselect");
  property p_zero_addr;
    $rose(sclk) && !csN && firstByte_q == STATUS_WRITE_CMD &&
      riseCnt_q inside {[4'h2:4'h4]} |-> dq == 8'h00;
  endproperty
  a_zero_addr: assert property (p_zero_addr)
    else $error("fixed address byte of a register write not zero");
endmodule

// ### tb/orc_bench.sv
// Self-checking bench: controller end and flash end joined by one link,
// plus a second flash end fed by raw frames from the bench.
// Assumes the package constants and the hand-over timing of both ends.
`timescale 1ns/1ps
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin \
  errorCnt++; $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
  end end
module orc_bench
  import orc_pkg::*;
  ;
  logic        clk;
  logic        rst;
  logic        start;
  orc_op_t     op;
  logic [31:0] addr;
  logic [7:0]  wdata;
  logic        writeEnable;
  logic        busy;
  logic        done;
  logic [7:0]  rdata;
  logic [7:0]  statusValue;
  logic [7:0]  configValue;
  logic        resetPulse;
  logic        regWritePulse;
  logic [7:0]  status2;
  logic [7:0]  config2;
  logic        reset2;
  logic        write2;
  logic [7:0]  frameQ[$];
  logic [7:0]  lastFrame[$];
  int          errorCnt;
  int          numChecks;
  int          cycles;
  int          resetCnt;
  int          writeCnt;
  int          write2Cnt;

  orc_link_if link();
  orc_link_if link2();

  orc_host i_orc_host (.clk(clk), .rst(rst), .link(link), .start(start),
    .op(op), .addr(addr), .wdata(wdata), .busy(busy), .done(done),
    .rdata(rdata));
  orc_device i_orc_device (.clk(clk), .rst(rst), .link(link),
    .writeEnableLatch(writeEnable), .statusValue(statusValue),
    .configValue(configValue), .resetPulse(resetPulse),
    .regWritePulse(regWritePulse));
  orc_device i_orc_device_2 (.clk(clk), .rst(rst), .link(link2),
    .writeEnableLatch(writeEnable), .statusValue(status2),
    .configValue(config2), .resetPulse(reset2), .regWritePulse(write2));
  orc_link_asserts i_orc_link_asserts (.clk(clk), .rst(rst),
    .sclk(link.sclk), .csN(link.csN), .hostDq(link.hostDq),
    .hostDqOe(link.hostDqOe), .devDq(link.devDq), .devDqOe(link.devDqOe),
    .dq(link.dq));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge link.sclk)
    if (!link.csN)
      frameQ.push_back(link.dq);

  always @(posedge link.csN)
  begin
    lastFrame = frameQ;
    frameQ    = {};
  end

  always @(posedge clk)
  begin
    cycles++;
    if (resetPulse === 1'b1)
      resetCnt++;
    if (reset2 === 1'b1)
      resetCnt++;
    if (regWritePulse === 1'b1)
      writeCnt++;
    if (write2 === 1'b1)
      write2Cnt++;
    if (cycles == 20000)
    begin
      errorCnt++;
      printVerdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic printVerdict();
    if (errorCnt == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic runOp(input orc_op_t o, input logic [31:0] a,
                       input logic [7:0] w);
    int n;
    @(posedge clk);
    op    <= o;
    addr  <= a;
    wdata <= w;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    `CHK(busy, 1'b1)
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
    repeat (4) @(negedge clk);
  endtask

  task automatic readChk(input orc_op_t o, input logic [31:0] a,
                         input logic [7:0] e);
    runOp(o, a, 8'h00);
    `CHK(rdata, e)
    `CHK(lastFrame.size(), 11)
    `CHK(lastFrame[10], e)
  endtask

  task automatic frameChk(input logic [7:0] e[$]);
    `CHK(lastFrame.size(), e.size())
    foreach (e[i])
      `CHK(lastFrame[i], e[i])
  endtask

  // Drives a raw frame on the second link; the link clock is moved only
  // on clock edges, thirteen clocks a period, the nearest to 64 ns.
  task automatic rawFrame(input logic [7:0] b[$]);
    @(posedge clk);
    link2.csN <= 1'b0;
    foreach (b[i])
    begin
      link2.hostDq   <= b[i];
      link2.hostDqOe <= 1'b1;
      repeat (6) @(posedge clk);
      link2.sclk <= 1'b1;
      repeat (7) @(posedge clk);
      link2.sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    link2.hostDqOe <= 1'b0;
    link2.hostDq   <= BUS_IDLE;
    link2.csN      <= 1'b1;
    repeat (40) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    op = OP_NOP;
    addr = 32'h0000_0000;
    wdata = 8'h00;
    writeEnable = 1'b0;
    link2.sclk = 1'b0;
    link2.csN = 1'b1;
    link2.hostDq = BUS_IDLE;
    link2.hostDqOe = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(statusValue, STATUS_RESET)
    `CHK(configValue, CONFIG_RESET)
    `CHK(link.dq, BUS_IDLE)
    runOp(OP_SR_WR, 32'h0000_0000, 8'h5a);
    `CHK(statusValue, STATUS_RESET)
    `CHK(writeCnt, 0)
    @(posedge clk);
    writeEnable <= 1'b1;
    runOp(OP_SR_WR, 32'h0000_0000, 8'ha5);
    frameChk('{8'h01, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha5});
    runOp(OP_CR_WR, 32'h0000_0000, 8'h3c);
    frameChk('{8'h01, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h01, 8'h3c});
    `CHK(statusValue, 8'ha5)
    `CHK(configValue, 8'h3c)
    `CHK(writeCnt, 2)
    readChk(OP_SR_RD, 32'h0000_0000, 8'ha5);
    readChk(OP_CR_RD, 32'h0000_0000, 8'h3c);
    runOp(OP_CR2_WR, 32'h1234_5603, 8'h77);
    frameChk('{8'h72, 8'h8d, 8'h12, 8'h34, 8'h56, 8'h03, 8'h77});
    runOp(OP_CR2_WR, 32'h0000_0005, 8'h88);
    readChk(OP_CR2_RD, 32'h0000_0003, 8'h77);
    readChk(OP_CR2_RD, 32'h0000_0005, 8'h88);
    readChk(OP_CR2_RD, 32'h0000_0000, 8'h00);
    rawFrame('{8'h01, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h99});
    `CHK(status2, 8'h00)
    rawFrame('{8'h01, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h02, 8'h66});
    `CHK(config2, 8'h00)
    `CHK(write2Cnt, 0)
    rawFrame('{8'h01, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00, 8'h99});
    `CHK(status2, 8'h99)
    runOp(OP_ARM, 32'h0000_0000, 8'h00);
    runOp(OP_NOP, 32'h0000_0000, 8'h00);
    frameChk('{8'h00, 8'hff});
    runOp(OP_RST, 32'h0000_0000, 8'h00);
    `CHK(resetCnt, 0)
    runOp(OP_ARM, 32'h0000_0000, 8'h00);
    frameChk('{8'h66, 8'h99});
    runOp(OP_RST, 32'h0000_0000, 8'h00);
    frameChk('{8'h99, 8'h66});
    `CHK(resetCnt, 1)
    runOp(OP_ARM, 32'h0000_0000, 8'h00);
    runOp(OP_SR_RD, 32'h0000_0000, 8'h00);
    runOp(OP_RST, 32'h0000_0000, 8'h00);
    `CHK(resetCnt, 1)
    rawFrame('{8'h66, 8'h99});
    rawFrame('{8'h99, 8'h66});
    `CHK(resetCnt, 2)
    printVerdict();
  end
endmodule
